// >>> core/owc_regs.svh
// Register map, field positions and reset values of the oscillator warm-up counter.
// Assumes a byte-wide register port with an 8-bit address.
`ifndef OWC_REGS_SVH
`define OWC_REGS_SVH

// Register offsets.
`define OWC_ADDR_LOWER_CTRL   8'h00
`define OWC_ADDR_UPPER_CTRL   8'h01
`define OWC_ADDR_LIMIT_LOW    8'h02
`define OWC_ADDR_LIMIT_HIGH   8'h03
`define OWC_ADDR_SYS_CTRL_TWO 8'h04
`define OWC_ADDR_COUNT_LOW    8'h05
`define OWC_ADDR_COUNT_HIGH   8'h06
`define OWC_ADDR_IRQ_STATUS   8'h07
`define OWC_ADDR_IRQ_MASK     8'h08
`define OWC_ADDR_STATE        8'h09

// Field positions in the counter control registers.
`define OWC_OUT_FLOP_BIT      7
`define OWC_RUN_BIT           3
`define OWC_SRC_MSB           6
`define OWC_SRC_LSB           4
`define OWC_MODE_MSB          2
`define OWC_MODE_LSB          0

// Field encodings.
`define OWC_SRC_SLOW          3'h4
`define OWC_SRC_FAST          3'h6
`define OWC_MODE_CASCADE      3'h3
`define OWC_MODE_WARMUP       3'h5

// Field positions in system control two.
`define OWC_FAST_EN_BIT       7
`define OWC_SLOW_EN_BIT       6
`define OWC_CLK_SEL_BIT       5

// Interrupt status bit of the match event.
`define OWC_IRQ_MATCH_BIT     0

// Reset values.
`define OWC_RST_CTRL          8'h00
`define OWC_RST_LIMIT         8'hff
`define OWC_RST_SYS_CTRL_TWO  8'h80
`define OWC_RST_IRQ           8'h00

// Programmable range of the limit; only the upper byte takes part.
`define OWC_LIMIT_MIN         16'h0100
`define OWC_LIMIT_MAX         16'hff00
`define OWC_SLOW_MAX_TIME_MS  1990
`define OWC_FAST_MIN_TIME_US  16
`define OWC_FAST_MAX_TIME_US  4080

`endif

// >>> core/owc_pkg.sv
// Types and decode functions shared by the warm-up counter modules.
// Assumes owc_regs.svh is on the include path.
`include "owc_regs.svh"

package owc_pkg;

    // Run state of the counter pair, Gray coded along idle, count, done.
    typedef enum logic [1:0] {
        OWC_IDLE  = 2'b00,
        OWC_COUNT = 2'b01,
        OWC_DONE  = 2'b11
    } owc_state_t;

    // True when both control registers select cascaded warm-up operation.
    function automatic logic owc_warm_mode(input logic [7:0] lower, input logic [7:0] upper);
        owc_warm_mode = (lower[`OWC_MODE_MSB:`OWC_MODE_LSB] == `OWC_MODE_CASCADE) &&
                        (upper[`OWC_MODE_MSB:`OWC_MODE_LSB] == `OWC_MODE_WARMUP);
    endfunction

    // Picks the source tick named by the lower control register.
    function automatic logic owc_src_tick(input logic [7:0] lower, input logic slow, input logic fast);
        unique case (lower[`OWC_SRC_MSB:`OWC_SRC_LSB])
            `OWC_SRC_SLOW: owc_src_tick = slow;
            `OWC_SRC_FAST: owc_src_tick = fast;
            default:       owc_src_tick = 1'b0;
        endcase
    endfunction

endpackage

// >>> core/owc_cnt_if.sv
// Interface between the warm-up counter top and its counter pair.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps

interface owc_cnt_if;
    logic       tick;
    logic       enable;
    logic       restart;
    logic [7:0] limit_high;
    logic [15:0] count;
    logic       match;

    modport ctrl (output tick, output enable, output restart, output limit_high,
                  input count, input match);
    modport pair (input tick, input enable, input restart, input limit_high,
                  output count, output match);
endinterface

// >>> core/owc_pair.sv
// Two cascaded 8-bit counters that form the 16-bit warm-up counter.
// Assumes tick is one clock wide per source clock edge.
`timescale 1ns/100ps

module owc_pair
    import owc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Control side.
    owc_cnt_if.pair  cnt
);

    logic [15:0] inc;
    logic [1:0]  carry;
    logic        hit;

    // Each byte stage steps when all lower stages wrap, giving one 16-bit count.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_stage
            logic [7:0] byte_q;
            if (g == 0) begin : g_first
                assign carry[g] = 1'b1;
            end else begin : g_next
                assign carry[g] = carry[g-1] & (g_stage[g-1].byte_q == 8'hff);
            end
            assign inc[8*g+7:8*g] = carry[g] ? 8'(byte_q + 8'h01) : byte_q;
            assign cnt.count[8*g+7:8*g] = byte_q;

            // Counts on a selected tick while enabled, clears on restart or on a limit hit, and holds otherwise.
            always_ff @(posedge clock) begin
                if (rst || cnt.restart) begin
                    byte_q <= 8'h00;
                end else if (cnt.enable && cnt.tick) begin
                    byte_q <= hit ? 8'h00 : inc[8*g+7:8*g];
                end
            end
        end
    endgenerate

    // Only the upper limit byte is compared; the low byte of the limit never matters.
    assign hit       = (inc[15:8] == cnt.limit_high);
    assign cnt.match = cnt.enable && cnt.tick && hit;

endmodule // owc_pair

// >>> core/owc_irq.sv
// Sticky interrupt status with mask and one level output.
// Assumes events are one-cycle pulses and clears are write-one strobes.
`timescale 1ns/100ps
`include "owc_regs.svh"

module owc_irq
    import owc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       rst,
    // Events and software access.
    input  wire logic [7:0] event_in,
    input  wire logic [7:0] clear_in,
    input  wire logic       mask_we,
    input  wire logic [7:0] mask_in,
    // State.
    output logic [7:0]      status_q,
    output logic [7:0]      mask_q,
    output logic            irq_q
);

    logic [7:0] status_d;

    // A set arriving with its own clear wins, so no event is lost.
    assign status_d = (status_q & ~clear_in) | event_in;

    always_ff @(posedge clock) begin
        if (rst) begin
            status_q <= `OWC_RST_IRQ;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mask_q <= `OWC_RST_IRQ;
        end else if (mask_we) begin
            mask_q <= mask_in;
        end
    end

    // The output follows the next status so it rises with the sticky bit.
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & (mask_we ? mask_in : mask_q));
        end
    end

endmodule // owc_irq

// >>> core/owc_top.sv
// Top of the oscillator warm-up counter with its register port.
// Assumes source ticks are one-clock pulses synchronous to clock.
`timescale 1ns/100ps
`include "owc_regs.svh"

module owc_top
    import owc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       rst,
    // Register port.
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_strobe,
    input  wire logic       rd_strobe,
    output logic [7:0]      rd_data_q,
    // Source clock ticks.
    input  wire logic       slow_source_clock,
    input  wire logic       fast_source_clock,
    // Oscillator and clock selection.
    output logic            fast_osc_enable_q,
    output logic            slow_osc_enable_q,
    output logic            sys_clock_select_q,
    // Timer output flops.
    output logic            lower_out_flop_q,
    output logic            upper_out_flop_q,
    // Interrupt.
    output logic            warmup_match_irq
);

    logic [7:0] lower_counter_control_q;
    logic [7:0] upper_counter_control_q;
    logic [7:0] limit_low_byte_q;
    logic [7:0] limit_high_byte_q;
    logic [7:0] system_control_two_q;
    owc_state_t state_q;
    owc_state_t state_d;
    logic       warm;
    logic       run;
    logic       start;
    logic       wr_lower;
    logic       wr_upper;
    logic       wr_sys;
    logic [7:0] irq_event;
    logic [7:0] irq_clear;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] rd_d;

    owc_cnt_if cnt ();

    // Write decodes.
    assign wr_lower = wr_strobe && (addr == `OWC_ADDR_LOWER_CTRL);
    assign wr_upper = wr_strobe && (addr == `OWC_ADDR_UPPER_CTRL);
    assign wr_sys   = wr_strobe && (addr == `OWC_ADDR_SYS_CTRL_TWO);

    // Lower control selects source and cascaded operation; 43H or 63H in warm-up use.
    always_ff @(posedge clock) begin
        if (rst) begin
            lower_counter_control_q <= `OWC_RST_CTRL;
        end else if (wr_lower) begin
            lower_counter_control_q <= wr_data;
        end
    end

    // Upper control holds mode and the pair's run bit; 05H leaves run low.
    always_ff @(posedge clock) begin
        if (rst) begin
            upper_counter_control_q <= `OWC_RST_CTRL;
        end else if (wr_upper) begin
            upper_counter_control_q <= wr_data;
        end
    end

    // Limit bytes; only the high byte feeds the compare.
    always_ff @(posedge clock) begin
        if (rst) begin
            limit_low_byte_q <= `OWC_RST_LIMIT;
        end else if (wr_strobe && addr == `OWC_ADDR_LIMIT_LOW) begin
            limit_low_byte_q <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            limit_high_byte_q <= `OWC_RST_LIMIT;
        end else if (wr_strobe && addr == `OWC_ADDR_LIMIT_HIGH) begin
            limit_high_byte_q <= wr_data;
        end
    end

    // System control two; the oscillator order is software's duty.
    always_ff @(posedge clock) begin
        if (rst) begin
            system_control_two_q <= `OWC_RST_SYS_CTRL_TWO;
        end else if (wr_sys) begin
            system_control_two_q <= wr_data;
        end
    end

    // Oscillator enables and clock select drive straight from their bits.
    always_ff @(posedge clock) begin
        if (rst) begin
            fast_osc_enable_q  <= 1'(`OWC_RST_SYS_CTRL_TWO >> `OWC_FAST_EN_BIT);
            slow_osc_enable_q  <= 1'(`OWC_RST_SYS_CTRL_TWO >> `OWC_SLOW_EN_BIT);
            sys_clock_select_q <= 1'(`OWC_RST_SYS_CTRL_TWO >> `OWC_CLK_SEL_BIT);
        end else if (wr_sys) begin
            fast_osc_enable_q  <= wr_data[`OWC_FAST_EN_BIT];
            slow_osc_enable_q  <= wr_data[`OWC_SLOW_EN_BIT];
            sys_clock_select_q <= wr_data[`OWC_CLK_SEL_BIT];
        end
    end

    // Output flops take their initial values on a control write. In warm-up mode they
    // never toggle, so a nonzero initial value shows as a steady level on the pin.
    always_ff @(posedge clock) begin
        if (rst) begin
            lower_out_flop_q <= 1'b0;
            upper_out_flop_q <= 1'b0;
        end else begin
            if (wr_lower) begin
                lower_out_flop_q <= wr_data[`OWC_OUT_FLOP_BIT];
            end
            if (wr_upper) begin
                upper_out_flop_q <= wr_data[`OWC_OUT_FLOP_BIT];
            end
        end
    end

    // Mode and run decode.
    assign warm  = owc_warm_mode(lower_counter_control_q, upper_counter_control_q);
    assign run   = upper_counter_control_q[`OWC_RUN_BIT];
    assign start = wr_upper && wr_data[`OWC_RUN_BIT] && !run;

    // Run state: idle until started, counting until stopped, done after a match.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            OWC_IDLE: begin
                if (run && warm) begin
                    state_d = OWC_COUNT;
                end
            end
            OWC_COUNT: begin
                if (!run || !warm) begin
                    state_d = OWC_IDLE;
                end else if (cnt.match) begin
                    state_d = OWC_DONE;
                end
            end
            OWC_DONE: begin
                if (!run || !warm) begin
                    state_d = OWC_IDLE;
                end
            end
            default: state_d = OWC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= OWC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // The pair keeps counting after a match until software stops it.
    assign cnt.tick       = owc_src_tick(lower_counter_control_q, slow_source_clock, fast_source_clock);
    assign cnt.enable     = warm && run && (state_q != OWC_IDLE);
    assign cnt.restart    = start;
    assign cnt.limit_high = limit_high_byte_q;

    owc_pair u_pair (
        .clock (clock),
        .rst   (rst),
        .cnt   (cnt)
    );

    // Match is the only event; status clears by writing a one.
    assign irq_event = 8'(cnt.match) << `OWC_IRQ_MATCH_BIT;
    assign irq_clear = (wr_strobe && addr == `OWC_ADDR_IRQ_STATUS) ? wr_data : 8'h00;

    owc_irq u_irq (
        .clock    (clock),
        .rst      (rst),
        .event_in (irq_event),
        .clear_in (irq_clear),
        .mask_we  (wr_strobe && addr == `OWC_ADDR_IRQ_MASK),
        .mask_in  (wr_data),
        .status_q (irq_status),
        .mask_q   (irq_mask),
        .irq_q    (warmup_match_irq)
    );

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        unique case (addr)
            `OWC_ADDR_LOWER_CTRL:   rd_d = lower_counter_control_q;
            `OWC_ADDR_UPPER_CTRL:   rd_d = upper_counter_control_q;
            `OWC_ADDR_LIMIT_LOW:    rd_d = limit_low_byte_q;
            `OWC_ADDR_LIMIT_HIGH:   rd_d = limit_high_byte_q;
            `OWC_ADDR_SYS_CTRL_TWO: rd_d = system_control_two_q;
            `OWC_ADDR_COUNT_LOW:    rd_d = cnt.count[7:0];
            `OWC_ADDR_COUNT_HIGH:   rd_d = cnt.count[15:8];
            `OWC_ADDR_IRQ_STATUS:   rd_d = irq_status;
            `OWC_ADDR_IRQ_MASK:     rd_d = irq_mask;
            `OWC_ADDR_STATE:        rd_d = {6'h00, state_q};
            default:                rd_d = 8'h00;
        endcase
    end

    // Read data stand one cycle after the strobe and only then.
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_strobe ? rd_d : 8'h00;
        end
    end

endmodule // owc_top

// >>> tb/owc_top_asserts.sv
// Concurrent checks on the ports of the warm-up counter top.
// Assumes it is bound to owc_top and sees nothing but its ports.
`timescale 1ns/100ps
`include "owc_regs.svh"

module owc_top_asserts (
    // Clock and reset.
    input wire logic       clock,
    input wire logic       rst,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_strobe,
    input wire logic       rd_strobe,
    input wire logic [7:0] rd_data_q,
    // Source clock ticks.
    input wire logic       slow_source_clock,
    input wire logic       fast_source_clock,
    // Oscillator and clock selection.
    input wire logic       fast_osc_enable_q,
    input wire logic       slow_osc_enable_q,
    input wire logic       sys_clock_select_q,
    // Timer output flops.
    input wire logic       lower_out_flop_q,
    input wire logic       upper_out_flop_q,
    // Interrupt.
    input wire logic       warmup_match_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Decoded writes keep the properties short.
    logic wr_ctl2, wr_low, wr_up, wr_mask;
    assign wr_ctl2 = wr_strobe && (addr == `OWC_ADDR_SYS_CTRL_TWO);
    assign wr_low  = wr_strobe && (addr == `OWC_ADDR_LOWER_CTRL);
    assign wr_up   = wr_strobe && (addr == `OWC_ADDR_UPPER_CTRL);
    assign wr_mask = wr_strobe && (addr == `OWC_ADDR_IRQ_MASK);

    // Each oscillator and clock-select bit of control two (bits 7, 6, 5) follows its written data bit one edge later.
    property p_fast_en; wr_ctl2 |=> fast_osc_enable_q == $past(wr_data[7]); endproperty
    a_fast_en: assert property (p_fast_en) else $error("fast enable does not follow write");
    property p_slow_en; wr_ctl2 |=> slow_osc_enable_q == $past(wr_data[6]); endproperty
    a_slow_en: assert property (p_slow_en) else $error("slow enable does not follow write");
    property p_clk_sel; wr_ctl2 |=> sys_clock_select_q == $past(wr_data[5]); endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select does not follow write");
    // Without a write the oscillator controls must not move on their own.
    property p_ctl2_hold;
        !wr_ctl2 |=> $stable({fast_osc_enable_q, slow_osc_enable_q, sys_clock_select_q});
    endproperty
    a_ctl2_hold: assert property (p_ctl2_hold) else $error("control two changed without write");
    // Output flops take bit 7 of their control byte.
    property p_low_flop; wr_low |=> lower_out_flop_q == $past(wr_data[7]); endproperty
    a_low_flop: assert property (p_low_flop) else $error("lower flop does not follow write");
    property p_up_flop; wr_up |=> upper_out_flop_q == $past(wr_data[7]); endproperty
    a_up_flop: assert property (p_up_flop) else $error("upper flop does not follow write");
    // The interrupt may only rise on a source tick or on a mask write.
    property p_irq_cause;
        $rose(warmup_match_irq) |-> $past(slow_source_clock || fast_source_clock) || $past(wr_mask);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose without a cause");
    property p_irq_mask_off; wr_mask && (wr_data == 8'h00) |=> !warmup_match_irq; endproperty
    a_irq_mask_off: assert property (p_irq_mask_off) else $error("interrupt high while masked");
endmodule // owc_top_asserts

bind owc_top owc_top_asserts u_owc_chk (
    .clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data_q(rd_data_q), .slow_source_clock(slow_source_clock),
    .fast_source_clock(fast_source_clock), .fast_osc_enable_q(fast_osc_enable_q),
    .slow_osc_enable_q(slow_osc_enable_q), .sys_clock_select_q(sys_clock_select_q),
    .lower_out_flop_q(lower_out_flop_q), .upper_out_flop_q(upper_out_flop_q),
    .warmup_match_irq(warmup_match_irq)
);

// >>> tb/owc_top_test.sv
// Self-checking bench of the warm-up counter through its register port.
// Assumes owc_top and the bound checker are compiled before it.
`timescale 1ns/100ps
`include "owc_regs.svh"

module owc_top_test;
    logic       clock, rst, wr_strobe, rd_strobe, slow_t, fast_t;
    logic [7:0] addr, wr_data, rd_data_q;
    logic       fast_en, slow_en, clk_sel, low_flop, up_flop, irq;
    int         n_fail, tests_run;

    owc_top dut (
        .clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_data_q(rd_data_q), .slow_source_clock(slow_t),
        .fast_source_clock(fast_t), .fast_osc_enable_q(fast_en), .slow_osc_enable_q(slow_en),
        .sys_clock_select_q(clk_sel), .lower_out_flop_q(low_flop), .upper_out_flop_q(up_flop),
        .warmup_match_irq(irq)
    );

    // Free-running 50 MHz clock.
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1;
        chk8(rd_data_q, exp);
    endtask

    // Holds the chosen ticks high for n cycles, one count per cycle.
    task automatic tick(input logic s, input logic f, input int n);
        repeat (n) begin
            @(posedge clock);
            slow_t <= s;
            fast_t <= f;
        end
        @(posedge clock);
        slow_t <= 1'b0;
        fast_t <= 1'b0;
        #1;
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short; the run needs about 66200 cycles, the limit is 90000.
    initial begin
        #1800000;
        n_fail++;
        end_sim();
    end

    initial begin
        n_fail = 0;
        tests_run = 0;
        {rst, wr_strobe, rd_strobe, slow_t, fast_t} = 5'h10;
        addr = 8'h00;
        wr_data = 8'h00;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        // Reset values, and an unmapped address that reads zero.
        rd(8'h00, 8'h00); rd(8'h01, 8'h00); rd(8'h02, 8'hff); rd(8'h03, 8'hff);
        rd(8'h04, 8'h80); rd(8'h07, 8'h00); rd(8'h20, 8'h00);
        chk1(fast_en, 1'b1);
        // Flops set then cleared by the documented control bytes.
        wr(8'h00, 8'hc3); chk1(low_flop, 1'b1);
        wr(8'h00, 8'h43); chk1(low_flop, 1'b0);
        wr(8'h01, 8'h85); chk1(up_flop, 1'b1);
        // Slow measurement: low limit byte ff must not matter.
        wr(8'h04, 8'hc0); chk1(slow_en, 1'b1);
        wr(8'h01, 8'h05); chk1(up_flop, 1'b0); chk1(low_flop, 1'b0);
        wr(8'h02, 8'hff); wr(8'h03, 8'h01); wr(8'h08, 8'h01);
        wr(8'h01, 8'h0d); rd(8'h09, 8'h01);
        tick(1'b1, 1'b1, 255);
        rd(8'h05, 8'hff); rd(8'h06, 8'h00); chk1(irq, 1'b0);
        tick(1'b1, 1'b0, 1); chk1(irq, 1'b1);
        rd(8'h07, 8'h01); rd(8'h05, 8'h00); rd(8'h09, 8'h03);
        tick(1'b1, 1'b0, 3); wr(8'h01, 8'h05);
        tick(1'b1, 1'b1, 5); rd(8'h05, 8'h03); rd(8'h09, 8'h00);
        wr(8'h04, 8'he0); chk1(clk_sel, 1'b1);
        wr(8'h04, 8'h60); chk1(fast_en, 1'b0);
        wr(8'h07, 8'h01); chk1(irq, 1'b0);
        // Fast measurement with the interrupt masked at first.
        wr(8'h04, 8'he0); chk1(fast_en, 1'b1);
        wr(8'h00, 8'h63); wr(8'h01, 8'h05); wr(8'h03, 8'h02); wr(8'h08, 8'h00);
        wr(8'h01, 8'h0d); tick(1'b1, 1'b1, 511);
        rd(8'h06, 8'h01); rd(8'h05, 8'hff);
        tick(1'b0, 1'b1, 1); rd(8'h07, 8'h01); chk1(irq, 1'b0);
        wr(8'h08, 8'h01); chk1(irq, 1'b1);
        wr(8'h01, 8'h05); wr(8'h04, 8'hc0); chk1(clk_sel, 1'b0);
        wr(8'h04, 8'h80); chk1(slow_en, 1'b0);
        wr(8'h07, 8'h01); chk1(irq, 1'b0);
        // Largest limit on the slow source.
        wr(8'h00, 8'h43); wr(8'h03, 8'hff); wr(8'h01, 8'h0d);
        tick(1'b1, 1'b0, 65279); chk1(irq, 1'b0);
        rd(8'h06, 8'hfe); rd(8'h05, 8'hff);
        tick(1'b1, 1'b0, 1); chk1(irq, 1'b1);
        rd(8'h06, 8'h00);
        end_sim();
    end
endmodule // owc_top_test
